/* inc/cctl_pkg.sv */
/*
 Constants, command encodings and carrier types for the five-channel
 counter control and command block.
 Assumes a host that writes command bytes and mode words on one clock.
*/
package cctl_pkg;
    localparam int NCNT = 5;
    localparam int CW = 16;
    // Mode word fields
    localparam int MF_FMT = 3;
    localparam int MF_DIR = 4;
    localparam int MF_REP = 5;
    localparam int MF_RLD = 6;
    localparam int MF_RTG = 7;
    localparam int MF_SRC_LO = 8;
    localparam int MF_GATE_LO = 13;
    localparam logic [15:0] MODE_RESET = 16'h0000;
    // Command groups
    localparam logic [2:0] OP_ARM = 3'h1;
    localparam logic [2:0] OP_LOAD = 3'h2;
    localparam logic [2:0] OP_LDARM = 3'h3;
    localparam logic [2:0] OP_DISSAVE = 3'h4;
    localparam logic [2:0] OP_SAVE = 3'h5;
    localparam logic [2:0] OP_DISARM = 3'h6;
    localparam logic [2:0] OP_EXT = 3'h7;
    localparam logic [1:0] SUB_CLR = 2'h0;
    localparam logic [1:0] SUB_SET = 2'h1;
    localparam logic [1:0] SUB_STEP = 2'h2;
    localparam logic [2:0] N_MIN = 3'h1;
    localparam logic [2:0] N_MAX = 3'h5;
    localparam logic [7:0] CMD_PTR_CLR = 8'hE0;
    localparam logic [7:0] CMD_FG_CLR = 8'hE6;
    localparam logic [7:0] CMD_BW_CLR = 8'hE7;
    localparam logic [7:0] CMD_PTR_SET = 8'hE8;
    localparam logic [7:0] CMD_FG_SET = 8'hEE;
    localparam logic [7:0] CMD_BW_SET = 8'hEF;
    localparam logic [7:0] CMD_PF_EN = 8'hF8;
    localparam logic [7:0] CMD_PF_DIS = 8'hF9;
    localparam logic [7:0] CMD_MRESET = 8'hFF;
    // Gating field codes
    localparam logic [2:0] G_NONE = 3'h0;
    localparam logic [2:0] G_TCPREV = 3'h1;
    localparam logic [2:0] G_HI_NEXT = 3'h2;
    localparam logic [2:0] G_HI_PREV = 3'h3;
    localparam logic [2:0] G_HI = 3'h4;
    localparam logic [2:0] G_LO = 3'h5;
    localparam logic [2:0] G_RISE = 3'h6;
    localparam logic [2:0] G_FALL = 3'h7;
    localparam logic [15:0] BCD_MAXV = 16'h9999;
    localparam logic [15:0] BIN_MAXV = 16'hFFFF;
    typedef struct packed {
        logic [2:0] gating;
        logic [4:0] source;
        logic retrig;
        logic reload_hold;
        logic repeat_on;
        logic count_up;
        logic bcd;
        logic [2:0] out_ctl;
    } cctl_mode_t;
    typedef struct packed {
        logic comp_two;
        logic comp_one;
        logic [4:0] outs;
        logic byte_ptr;
    } cctl_status_t;
endpackage

/* hdl/cctl_core.sv */
/*
 Counter control and command logic of a five-channel 16-bit counter.
 Assumes source, gate and comparator pins are asynchronous; command and
 register writes are single-cycle strobes from logic on clk.
*/
`timescale 1ns/1ps
module cctl_core
    import cctl_pkg::*;
#(
    parameter int NSRC = 16
) (
    input wire logic clk, // 10 MHz clock
    input wire logic resetn, // Async reset, active low
    input wire logic cmd_wr, // Command byte strobe
    input wire logic [7:0] cmd_data, // Command byte
    input wire logic mode_wr, // Mode word write strobe
    input wire logic load_wr, // Load register write strobe
    input wire logic hold_wr, // Hold register write strobe
    input wire logic [2:0] reg_sel, // Counter index 0..4
    input wire logic [15:0] reg_wdata, // Register write data
    input wire logic [NSRC-1:0] src_pins, // Count source pins
    input wire logic [NCNT-1:0] gate_pins, // Gate pins
    input wire logic [1:0] comp_pins, // Comparator state pins
    input wire logic byte_ptr, // Byte pointer from bus logic
    output logic [7:0] status_q, // Status register
    output logic [NCNT*CW-1:0] count_q, // Counter values
    output logic [NCNT*CW-1:0] hold_q, // Hold register values
    output logic [NCNT-1:0] tc_q, // Terminal count pulses
    output logic [NCNT-1:0] out_q, // Counter toggle outputs
    output logic [NCNT-1:0] armed_q, // Armed flags
    output logic ptr_seq_off_q, // Pointer sequencing disabled
    output logic freq_gate_off_q, // Frequency output gated off
    output logic bus16_q, // 16-bit bus mode
    output logic prefetch_q // Write prefetch enabled
);
    // ==========================================================
    // Input synchronisers and edges
    logic [NSRC-1:0] src_m, src_s, src_p;
    logic [NCNT-1:0] gate_m, gate_s, gate_p;
    logic [1:0] comp_m, comp_s;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            src_m <= '0;
            src_s <= '0;
            src_p <= '0;
            gate_m <= '0;
            gate_s <= '0;
            gate_p <= '0;
            comp_m <= '0;
            comp_s <= '0;
        end else begin
            src_m <= src_pins;
            src_s <= src_m;
            src_p <= src_s;
            gate_m <= gate_pins;
            gate_s <= gate_m;
            gate_p <= gate_s;
            comp_m <= comp_pins;
            comp_s <= comp_m;
        end
    end
    wire logic [NSRC-1:0] src_edge = src_s & ~src_p;
    wire logic [NCNT-1:0] gate_rise = gate_s & ~gate_p;
    wire logic [NCNT-1:0] gate_fall = ~gate_s & gate_p;

    // ==========================================================
    // Command decode
    wire logic [2:0] op = cmd_data[7:5];
    wire logic [1:0] sub = cmd_data[4:3];
    wire logic [2:0] ncode = cmd_data[2:0];
    wire logic mreset = cmd_wr && (cmd_data == CMD_MRESET);
    wire logic n_ok = (ncode >= N_MIN) && (ncode <= N_MAX);
    logic [NCNT-1:0] n_hot;
    always_comb begin
        n_hot = '0;
        if (n_ok) begin
            n_hot[ncode - N_MIN] = 1'b1;
        end
    end
    wire logic ext_cmd = cmd_wr && (op == OP_EXT);
    wire logic [NCNT-1:0] sel = cmd_data[NCNT-1:0];
    wire logic [NCNT-1:0] c_arm = (cmd_wr && (op == OP_ARM || op == OP_LDARM)) ? sel : '0;
    wire logic [NCNT-1:0] c_load = (cmd_wr && (op == OP_LOAD || op == OP_LDARM)) ? sel : '0;
    wire logic [NCNT-1:0] c_save = (cmd_wr && (op == OP_SAVE || op == OP_DISSAVE)) ? sel : '0;
    wire logic [NCNT-1:0] c_dis = (cmd_wr && (op == OP_DISARM || op == OP_DISSAVE)) ? sel : '0;
    wire logic [NCNT-1:0] c_tclr = (ext_cmd && sub == SUB_CLR) ? n_hot : '0;
    wire logic [NCNT-1:0] c_tset = (ext_cmd && sub == SUB_SET) ? n_hot : '0;
    wire logic [NCNT-1:0] c_step = (ext_cmd && sub == SUB_STEP) ? n_hot : '0;

    // ==========================================================
    // Device-level control bits
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ptr_seq_off_q <= 1'b0;
            freq_gate_off_q <= 1'b0;
            bus16_q <= 1'b0;
            prefetch_q <= 1'b0;
        end else if (mreset) begin
            ptr_seq_off_q <= 1'b0;
            freq_gate_off_q <= 1'b0;
            bus16_q <= 1'b0;
            prefetch_q <= 1'b0;
        end else if (cmd_wr) begin
            if (cmd_data == CMD_PTR_CLR) ptr_seq_off_q <= 1'b0;
            if (cmd_data == CMD_PTR_SET) ptr_seq_off_q <= 1'b1;
            if (cmd_data == CMD_FG_CLR) freq_gate_off_q <= 1'b0;
            if (cmd_data == CMD_FG_SET) freq_gate_off_q <= 1'b1;
            if (cmd_data == CMD_BW_CLR) bus16_q <= 1'b0;
            if (cmd_data == CMD_BW_SET) bus16_q <= 1'b1;
            if (cmd_data == CMD_PF_EN) prefetch_q <= 1'b1;
            if (cmd_data == CMD_PF_DIS) prefetch_q <= 1'b0;
        end
    end

    // ==========================================================
    // Status register
    // status layout
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_q <= '0;
        end else begin
            status_q <= {comp_s[1], comp_s[0], out_q, byte_ptr};
        end
    end

    // ==========================================================
    // BCD / binary step function
    function automatic logic [15:0] step_val(input logic [15:0] v, input logic up,
                                             input logic bcd);
        logic [15:0] r;
        logic carry;
        r = v;
        carry = 1'b1;
        if (!bcd) begin
            r = up ? v + 16'h0001 : v - 16'h0001;
        end else begin
            for (int d = 0; d < 4; d++) begin
                if (carry) begin
                    if (up) begin
                        carry = (v[d*4 +: 4] == 4'h9);
                        r[d*4 +: 4] = carry ? 4'h0 : v[d*4 +: 4] + 4'h1;
                    end else begin
                        carry = (v[d*4 +: 4] == 4'h0);
                        r[d*4 +: 4] = carry ? 4'h9 : v[d*4 +: 4] - 4'h1;
                    end
                end
            end
        end
        return r;
    endfunction

    // ==========================================================
    // Per-counter logic
    genvar i;
    generate
        for (i = 0; i < NCNT; i++) begin : g_cnt
            cctl_mode_t mode_q;
            logic [CW-1:0] load_q, cnt, hld;
            logic alt_q, run_q;
            wire logic [2:0] gm = mode_q.gating;
            // source field picks one synchronised input
            wire logic src_hit = src_edge[mode_q.source[3:0]];
            wire logic own_g = gate_s[i];
            wire logic nxt_g = gate_s[(i + 1) % NCNT];
            wire logic prv_g = gate_s[(i + NCNT - 1) % NCNT];
            wire logic prv_tc = tc_q[(i + NCNT - 1) % NCNT];
            logic g_level, g_edge, may_count;
            // modes arise from control bits plus this gating field
            always_comb begin
                g_level = 1'b1;
                g_edge = 1'b0;
                unique case (gm)
                    G_NONE: g_level = 1'b1;
                    G_TCPREV: g_level = prv_tc;
                    G_HI_NEXT: g_level = nxt_g;
                    G_HI_PREV: g_level = prv_g;
                    G_HI: g_level = own_g;
                    G_LO: g_level = ~own_g;
                    G_RISE: g_edge = gate_rise[i];
                    G_FALL: g_edge = gate_fall[i];
                endcase
            end
            wire logic edge_mode = (gm == G_RISE) || (gm == G_FALL);
            wire logic retrig = (gm != G_NONE) && mode_q.retrig && g_edge;
            // ungated, level gate suspends, edge start
            always_comb begin
                may_count = armed_q[i] && src_hit;
                if (edge_mode) may_count = may_count && run_q;
                else may_count = may_count && g_level;
            end
            wire logic [CW-1:0] maxv = mode_q.bcd ? BCD_MAXV : BIN_MAXV;
            wire logic at_end = mode_q.count_up ? (cnt == maxv) : (cnt == 16'h0001);
            wire logic hit_tc = (may_count || c_step[i]) && at_end;
            // reload source selection, gate level choice
            logic use_hold;
            always_comb begin
                use_hold = 1'b0;
                if (mode_q.reload_hold) begin
                    if (gm == G_NONE && mode_q.retrig) use_hold = ~own_g;
                    // After a Load transfer the next reload comes from Hold
                    else if (gm == G_NONE || edge_mode) use_hold = ~alt_q;
                    else use_hold = ~g_level;
                end
            end
            wire logic [CW-1:0] reload = use_hold ? hld : load_q;
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    mode_q <= MODE_RESET;
                    load_q <= '0;
                end else if (mreset) begin
                    mode_q <= MODE_RESET;
                    load_q <= '0;
                end else begin
                    // host writes mode only while disarmed
                    if (mode_wr && reg_sel == 3'(i)) mode_q <= reg_wdata;
                    if (load_wr && reg_sel == 3'(i)) load_q <= reg_wdata;
                end
            end
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    cnt <= '0;
                    hld <= '0;
                    alt_q <= 1'b0;
                    run_q <= 1'b0;
                    armed_q[i] <= 1'b0;
                    tc_q[i] <= 1'b0;
                    out_q[i] <= 1'b0;
                end else if (mreset) begin
                    cnt <= '0;
                    hld <= '0;
                    alt_q <= 1'b0;
                    run_q <= 1'b0;
                    armed_q[i] <= 1'b0;
                    tc_q[i] <= 1'b0;
                    out_q[i] <= 1'b0;
                end else begin
                    tc_q[i] <= hit_tc;
                    if (hold_wr && reg_sel == 3'(i)) hld <= reg_wdata;
                    if (c_save[i]) hld <= cnt;
                    if (retrig && armed_q[i]) begin
                        hld <= cnt;
                        cnt <= load_q;
                        alt_q <= 1'b0;
                    end else if (hit_tc) begin
                        cnt <= reload;
                        alt_q <= ~alt_q;
                    end else if (may_count || c_step[i]) begin
                        cnt <= step_val(cnt, mode_q.count_up, mode_q.bcd);
                    end
                    if (c_load[i]) begin
                        cnt <= load_q;
                        alt_q <= 1'b0;
                    end
                    // edge modes start counting on the gate edge, with or without retrigger
                    if (edge_mode && g_edge) run_q <= 1'b1;
                    if (c_arm[i]) armed_q[i] <= 1'b1;
                    if (hit_tc && !mode_q.repeat_on) begin
                        armed_q[i] <= 1'b0;
                        run_q <= 1'b0;
                    end
                    if (c_dis[i]) begin
                        armed_q[i] <= 1'b0;
                        run_q <= 1'b0;
                    end
                    if (hit_tc) out_q[i] <= ~out_q[i];
                    if (c_tclr[i]) out_q[i] <= 1'b0;
                    if (c_tset[i]) out_q[i] <= 1'b1;
                end
            end
            assign count_q[i*CW +: CW] = cnt;
            assign hold_q[i*CW +: CW] = hld;
        end
    endgenerate
endmodule // cctl_core

/* verification/cctl_props.sv */
/*
 Port checker for the counter control block.
 Assumes binding onto cctl_core with one clock and async active-low reset.
*/
`timescale 1ns/1ps
module cctl_props
    import cctl_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic resetn, // Reset, active low
    input wire logic cmd_wr, // Command strobe
    input wire logic [7:0] cmd_data, // Command byte
    input wire logic [7:0] status_q, // Status
    input wire logic [NCNT*CW-1:0] count_q, // Counts
    input wire logic [NCNT*CW-1:0] hold_q, // Holds
    input wire logic [NCNT-1:0] tc_q, // Terminal count
    input wire logic [NCNT-1:0] out_q, // Toggle outputs
    input wire logic [NCNT-1:0] armed_q, // Armed flags
    input wire logic ptr_seq_off_q, // Pointer sequencing off
    input wire logic freq_gate_off_q, // Frequency gate off
    input wire logic bus16_q, // Bus width
    input wire logic prefetch_q // Prefetch
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [4:0] nsel;
    // ==========================================
    // Decode of single counter code
    always_comb nsel = (cmd_data[2:0] >= N_MIN && cmd_data[2:0] <= N_MAX) ?
        (5'h01 << (cmd_data[2:0] - 3'h1)) : 5'h00;
    sequence s_act(op); cmd_wr && cmd_data[7:5] == op; endsequence
    sequence s_ext(sub); cmd_wr && cmd_data[7:3] == {OP_EXT, sub} && nsel != 5'h00; endsequence
    // ==========================================
    // Assertions
    AST_ARM: assert property ((s_act(OP_ARM) or s_act(OP_LDARM)) |=>
        (armed_q & $past(cmd_data[4:0])) == $past(cmd_data[4:0])) else $error("arm missed");
    AST_DISARM: assert property ((s_act(OP_DISARM) or s_act(OP_DISSAVE)) |=>
        (armed_q & $past(cmd_data[4:0])) == 5'h00) else $error("disarm missed");
    AST_SAVE: assert property (cmd_wr && cmd_data[7:5] == OP_SAVE && cmd_data[0] |=>
        hold_q[15:0] == $past(count_q[15:0]) || hold_q[15:0] == count_q[15:0])
        else $error("save missed");
    AST_TSET: assert property (s_ext(SUB_SET) |=> (out_q & $past(nsel)) == $past(nsel))
        else $error("toggle set missed");
    AST_TCLR: assert property (s_ext(SUB_CLR) |=> (out_q & $past(nsel)) == 5'h00)
        else $error("toggle clear missed");
    AST_PTR: assert property (cmd_wr && (cmd_data == CMD_PTR_SET || cmd_data == CMD_PTR_CLR)
        |=> ptr_seq_off_q == $past(cmd_data[3])) else $error("pointer bit wrong");
    AST_FG: assert property (cmd_wr && (cmd_data == CMD_FG_SET || cmd_data == CMD_FG_CLR)
        |=> freq_gate_off_q == $past(cmd_data[3])) else $error("freq gate wrong");
    AST_BW: assert property (cmd_wr && (cmd_data == CMD_BW_SET || cmd_data == CMD_BW_CLR)
        |=> bus16_q == $past(cmd_data[3])) else $error("bus width wrong");
    AST_PF: assert property (cmd_wr && (cmd_data == CMD_PF_EN || cmd_data == CMD_PF_DIS)
        |=> prefetch_q == !$past(cmd_data[0])) else $error("prefetch wrong");
    AST_MRST: assert property (cmd_wr && cmd_data == CMD_MRESET |=> armed_q == 5'h00 &&
        out_q == 5'h00 && count_q == '0 && !prefetch_q && !bus16_q) else $error("reset cmd");
    AST_TOG: assert property ($rose(tc_q[0]) |-> ##[0:1] $changed(out_q[0]))
        else $error("no toggle at terminal count");
    AST_STAT: assert property ($changed(out_q) |-> ##[1:2] status_q[5:1] == out_q)
        else $error("status outputs stale");
endmodule // cctl_props

/* verification/cctl_host.sv */
/*
 Host model issuing command bytes and register writes.
 Assumes the bench calls its tasks; strobes last one clock.
*/
`timescale 1ns/1ps
module cctl_host
    import cctl_pkg::*;
(
    input wire logic clk, // Clock
    output logic cmd_wr, // Command strobe
    output logic [7:0] cmd_data, // Command byte
    output logic mode_wr, // Mode write
    output logic load_wr, // Load write
    output logic hold_wr, // Hold write
    output logic [2:0] reg_sel, // Counter index
    output logic [15:0] reg_wdata // Write data
);
    initial begin
        {cmd_wr, mode_wr, load_wr, hold_wr} <= 4'h0;
        cmd_data <= 8'h00;
        reg_sel <= 3'h0;
        reg_wdata <= 16'h0000;
    end
    task cmd(input logic [7:0] c, input int gap = 0);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        cmd_wr <= 1'b1;
        cmd_data <= c;
        @(posedge clk);
        cmd_wr <= 1'b0;
        cmd_data <= ~c;
    endtask
    task wr(input int kind, input logic [2:0] sel, input logic [15:0] d);
        @(posedge clk);
        mode_wr <= (kind == 0);
        load_wr <= (kind == 1);
        hold_wr <= (kind == 2);
        reg_sel <= sel;
        reg_wdata <= d;
        @(posedge clk);
        {mode_wr, load_wr, hold_wr} <= 3'h0;
        reg_wdata <= ~d;
    endtask
endmodule // cctl_host

/* verification/tb_top.sv */
/*
 Self-checking bench for the counter control block.
 Assumes cctl_host drives the command side; bench drives pins.
*/
`timescale 1ns/1ps
module tb_top
    import cctl_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic cmd_wr, mode_wr, load_wr, hold_wr, byte_ptr;
    logic [7:0] cmd_data, status_q;
    logic [2:0] reg_sel;
    logic [15:0] reg_wdata, src_pins;
    logic [4:0] gate_pins, tc_q, out_q, armed_q;
    logic [1:0] comp_pins;
    logic [79:0] count_q, hold_q;
    logic ptr_seq_off_q, freq_gate_off_q, bus16_q, prefetch_q;
    int err_total = 0;
    int cmp_count = 0;
    cctl_host u_host (.clk(clk), .cmd_wr(cmd_wr), .cmd_data(cmd_data), .mode_wr(mode_wr),
        .load_wr(load_wr), .hold_wr(hold_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata));
    cctl_core dut (.clk(clk), .resetn(resetn), .cmd_wr(cmd_wr), .cmd_data(cmd_data),
        .mode_wr(mode_wr), .load_wr(load_wr), .hold_wr(hold_wr), .reg_sel(reg_sel),
        .reg_wdata(reg_wdata), .src_pins(src_pins), .gate_pins(gate_pins),
        .comp_pins(comp_pins), .byte_ptr(byte_ptr), .status_q(status_q), .count_q(count_q),
        .hold_q(hold_q), .tc_q(tc_q), .out_q(out_q), .armed_q(armed_q),
        .ptr_seq_off_q(ptr_seq_off_q), .freq_gate_off_q(freq_gate_off_q),
        .bus16_q(bus16_q), .prefetch_q(prefetch_q));
    initial begin
        forever #50 clk = ~clk;
    end
    // ==========================================
    // Helpers
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task final_report;
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task pulse(input int n, input logic [15:0] m = 16'hFFFF);
        repeat (n) begin
            @(posedge clk);
            src_pins <= m;
            cyc(2);
            src_pins <= 16'h0000;
            cyc(4);
        end
    endtask
    task gate_edge;
        @(posedge clk);
        gate_pins[2] <= 1'b1;
        cyc(5);
        gate_pins[2] <= 1'b0;
        cyc(4);
    endtask
    function logic [15:0] cnt(input int i);
        return count_q[16*i +: 16];
    endfunction
    function logic [15:0] hld(input int i);
        return hold_q[16*i +: 16];
    endfunction
    function cctl_mode_t mk(input logic [2:0] g, input logic rt, rep, up, bcd);
        mk = '0;
        mk.gating = g;
        mk.retrig = rt;
        mk.repeat_on = rep;
        mk.count_up = up;
        mk.bcd = bcd;
    endfunction
    // ==========================================
    // Scenarios
    task t_repeat;
        check("reset armed", {11'h0, armed_q}, 16'h0000);
        u_host.wr(0, 3'h0, mk(G_NONE, 1'b0, 1'b1, 1'b0, 1'b0));
        u_host.wr(1, 3'h0, 16'h0003);
        u_host.cmd(8'h61);
        cyc(1);
        check("cnt1 load", cnt(0), 16'h0003);
        pulse(2);
        check("cnt1 down", cnt(0), 16'h0001);
        pulse(1);
        check("cnt1 reload", cnt(0), 16'h0003);
        check("counter_one_output_state toggle", {15'h0, out_q[0]}, 16'h0001);
        check("arm1 repeat", {15'h0, armed_q[0]}, 16'h0001);
        check("status counter_one_output_state", {15'h0, status_q[1]}, 16'h0001);
    endtask
    task t_save;
        u_host.cmd(8'hA1, 3);
        cyc(1);
        check("hold1 save", hld(0), 16'h0003);
        pulse(1);
        check("cnt1 runs", cnt(0), 16'h0002);
        u_host.cmd(8'h81);
        cyc(1);
        check("hold1 dsave", hld(0), 16'h0002);
        check("arm1 off", {15'h0, armed_q[0]}, 16'h0000);
        pulse(1);
        check("cnt1 stopped", cnt(0), 16'h0002);
    endtask
    task t_oneshot;
        u_host.wr(0, 3'h0, mk(G_NONE, 1'b0, 1'b0, 1'b0, 1'b0));
        u_host.wr(1, 3'h0, 16'h0002);
        u_host.cmd(8'h61);
        pulse(2);
        check("arm1 oneshot", {15'h0, armed_q[0]}, 16'h0000);
        check("cnt1 oneshot", cnt(0), 16'h0002);
        check("counter_one_output_state back", {15'h0, out_q[0]}, 16'h0000);
    endtask
    task t_bcd_step;
        u_host.wr(0, 3'h1, mk(G_NONE, 1'b0, 1'b1, 1'b1, 1'b1));
        u_host.wr(1, 3'h1, 16'h0009);
        u_host.cmd(8'h62);
        pulse(1);
        check("cnt2 bcd up", cnt(1), 16'h0010);
        u_host.cmd(8'hF2);
        cyc(1);
        check("cnt2 step", cnt(1), 16'h0011);
        u_host.cmd(8'hF6);
        u_host.cmd(8'hF0);
        cyc(1);
        check("cnt2 bad step", cnt(1), 16'h0011);
        u_host.cmd(8'hC2);
        cyc(1);
        check("arm2 off", {15'h0, armed_q[1]}, 16'h0000);
        u_host.cmd(8'hED);
        cyc(1);
        check("counter_five_output_state set", {15'h0, out_q[4]}, 16'h0001);
        u_host.cmd(8'hE5);
        cyc(1);
        check("counter_five_output_state clr", {15'h0, out_q[4]}, 16'h0000);
    endtask
    task t_retrig;
        u_host.wr(0, 3'h2, mk(G_RISE, 1'b1, 1'b1, 1'b0, 1'b0));
        u_host.wr(1, 3'h2, 16'h0005);
        u_host.cmd(8'h64);
        gate_edge();
        check("hold3 edge", hld(2), 16'h0005);
        pulse(2);
        check("cnt3 gated", cnt(2), 16'h0003);
        gate_edge();
        check("hold3 retrig", hld(2), 16'h0003);
        check("cnt3 retrig", cnt(2), 16'h0005);
    endtask
    // Counter 5: ungated, alternating reload, source 3; counter 4: own gate low
    task t_gate_alt;
        gate_pins <= 5'h08;
        u_host.wr(0, 3'h4, 16'h0360);
        u_host.wr(1, 3'h4, 16'h0001);
        u_host.wr(2, 3'h4, 16'h0002);
        u_host.wr(0, 3'h3, 16'hA320);
        u_host.wr(1, 3'h3, 16'h0005);
        u_host.cmd(8'h78);
        pulse(1, 16'h0001);
        check("cnt5 other src", cnt(4), 16'h0001);
        pulse(1, 16'h0008);
        check("cnt5 hold reload", cnt(4), 16'h0002);
        check("cnt4 gated off", cnt(3), 16'h0005);
        gate_pins <= 5'h00;
        pulse(2, 16'h0008);
        check("cnt5 load reload", cnt(4), 16'h0001);
        check("cnt4 gate on", cnt(3), 16'h0003);
    endtask
    task t_status_dev;
        logic [7:0] cmds [8];
        logic [3:0] ex [8];
        cmds = '{CMD_PTR_SET, CMD_PTR_CLR, CMD_FG_SET, CMD_FG_CLR, CMD_BW_SET, CMD_BW_CLR,
            CMD_PF_EN, CMD_PF_DIS};
        ex = '{4'h8, 4'h0, 4'h4, 4'h0, 4'h2, 4'h0, 4'h1, 4'h0};
        @(posedge clk);
        comp_pins <= 2'h2;
        byte_ptr <= 1'b1;
        cyc(5);
        check("status bits", {13'h0, status_q[7:6], status_q[0]}, 16'h0005);
        comp_pins <= 2'h1;
        byte_ptr <= 1'b0;
        cyc(5);
        check("status bits2", {13'h0, status_q[7:6], status_q[0]}, 16'h0002);
        u_host.wr(2, 3'h3, 16'h1234);
        cyc(1);
        check("hold4 write", hld(3), 16'h1234);
        for (int i = 0; i < 8; i++) begin
            u_host.cmd(cmds[i]);
            cyc(1);
            check("device bits", {12'h0, ptr_seq_off_q, freq_gate_off_q, bus16_q, prefetch_q},
                {12'h0, ex[i]});
        end
        u_host.cmd(CMD_PF_EN);
        u_host.cmd(8'h21);
        u_host.cmd(CMD_MRESET);
        cyc(1);
        check("mreset", {10'h0, armed_q, prefetch_q}, 16'h0000);
        check("mreset cnt3", cnt(2), 16'h0000);
        u_host.cmd(CMD_BW_SET);
        resetn <= 1'b0;
        cyc(2);
        check("async reset bus", {15'h0, bus16_q}, 16'h0000);
        resetn <= 1'b1;
        cyc(2);
    endtask
    // ==========================================
    // Main sequence and watchdog
    initial begin
        {byte_ptr, comp_pins, gate_pins, src_pins} <= '0;
        cyc(6);
        resetn <= 1'b1;
        t_repeat();
        t_save();
        t_oneshot();
        t_bcd_step();
        t_retrig();
        t_gate_alt();
        t_status_dev();
        final_report();
    end
    initial begin
        cyc(20000);
        err_total++;
        final_report();
    end
endmodule // tb_top
bind cctl_core cctl_props u_props (.clk(clk), .resetn(resetn), .cmd_wr(cmd_wr),
    .cmd_data(cmd_data), .status_q(status_q), .count_q(count_q), .hold_q(hold_q),
    .tc_q(tc_q), .out_q(out_q), .armed_q(armed_q), .ptr_seq_off_q(ptr_seq_off_q),
    .freq_gate_off_q(freq_gate_off_q), .bus16_q(bus16_q), .prefetch_q(prefetch_q));
